// ==== desc_buffer.sv ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module desc_buffer #(
  parameter int WIDTH = 35
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic [WIDTH-1:0] tail;
    logic [1:0] count;
    logic valid;
    logic ready;
  } buf_type;

  buf_type s_q;
  buf_type s_d;

  // Next state: head is always the oldest word, so outputs are plain flops
  always_comb begin
    logic push;
    logic pop;
    logic [1:0] left;
    push = 1'b0;
    pop = 1'b0;
    left = 2'h0;
    s_d = s_q;
    push = in_valid && s_q.ready;
    pop = s_q.valid && out_ready;
    left = s_q.count;
    if (pop) begin
      s_d.head = s_q.tail;
      left = s_q.count - 2'h1;
    end
    if (push) begin
      if (left == 2'h0) begin
        s_d.head = in_data;
      end else begin
        s_d.tail = in_data;
      end
      left = left + 2'h1;
    end
    s_d.count = left;
    s_d.valid = (left != 2'h0);
    s_d.ready = (left != 2'h2); // Full stops the filler, no word lost
  end

  // Register the state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign in_ready = s_q.ready;
  assign out_valid = s_q.valid;
  assign out_data = s_q.head;

endmodule : desc_buffer

// ==== eth_rx_desc_wake_pattern.sv ====
// Receive descriptor write-back, VLAN priority capture and wake pattern detection
`timescale 1ns/10ps
module eth_rx_desc_wake_pattern (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Received byte stream
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_last,
  output logic rx_ready,
  // Descriptor write-back
  input wire logic [31:0] desc_buf_ptr,
  output logic [31:0] desc_word,
  output logic [2:0] desc_index,
  output logic desc_valid,
  input wire logic desc_ready,
  // Wake request
  output logic wake_event
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] st_low;
    logic [15:0] st_high;
    logic wake;
    logic [31:0] rdata;
    logic [2:0] ff_run;
    logic match_on;
    logic [2:0] pos;
    logic [3:0] rep;
    logic [15:0] count;
    logic [7:0] tpid_hi;
    logic vlan;
    logic [2:0] prio;
    logic [15:0] len;
    logic [31:0] ptr;
    eth_rx_pkg::wr_state_type wr;
    logic [2:0] idx;
    logic rx_ready;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic beat;
  logic hit;
  logic start;
  logic clr_wake;
  logic buf_ready;
  logic buf_push;
  logic [31:0] word;
  logic [eth_rx_pkg::BUFFER_WIDTH-1:0] buf_out;

  // Station address byte in wire order, first byte in the top of the low word
  function automatic logic [7:0] station_byte(input logic [2:0] p, input logic [31:0] lo,
                                              input logic [15:0] hi);
    logic [7:0] b;
    b = 8'h00;
    if (p == 3'h0) begin
      b = lo[31:24];
    end else if (p == 3'h1) begin
      b = lo[23:16];
    end else if (p == 3'h2) begin
      b = lo[15:8];
    end else if (p == 3'h3) begin
      b = lo[7:0];
    end else if (p == 3'h4) begin
      b = hi[15:8];
    end else begin
      b = hi[7:0];
    end
    return b;
  endfunction : station_byte

  // Descriptor halfword pair for one 32-bit word, big-endian within the word
  function automatic logic [31:0] desc_pair(input logic [2:0] i, input logic [15:0] len,
                                            input logic [31:0] ptr, input logic [2:0] prio,
                                            input logic vlan);
    logic [15:0] status;
    logic [15:0] csum;
    logic [31:0] w;
    status = 16'h0000;
    csum = 16'h0000;
    w = 32'h0000_0000;
    status[eth_rx_pkg::EMPTY_BIT] = 1'b0; // Filled by hardware
    status[eth_rx_pkg::LAST_BIT] = 1'b1; // One buffer per frame, always last
    csum[eth_rx_pkg::PRIO_LSB +: 3] = prio;
    csum[eth_rx_pkg::VLAN_FLAG_BIT] = vlan;
    if (i == 3'h0) begin
      w = {status, len};
    end else if (i == 3'h1) begin
      w = ptr;
    end else if (i == 3'h2) begin
      w = {16'h0000, csum};
    end
    return w;
  endfunction : desc_pair

  // ****************************************
  // Stream handshake and word assembly
  // ****************************************
  assign beat = rx_valid && s_q.rx_ready;
  assign clr_wake = reg_write && (reg_addr == eth_rx_pkg::WAKE_STATUS_OFFSET) &&
                    reg_wdata[eth_rx_pkg::WAKE_FLAG_BIT];
  assign buf_push = (s_q.wr == eth_rx_pkg::WR_EMIT) && buf_ready;

  // Swap reverses all four bytes, so status and length trade places
  always_comb begin
    logic [31:0] w;
    w = desc_pair(s_q.idx, s_q.len, s_q.ptr, s_q.prio, s_q.vlan);
    if (s_q.ctrl[eth_rx_pkg::BYTE_SWAP_BIT]) begin
      word = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end else begin
      word = w;
    end
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic [2:0] last_word;
    last_word = eth_rx_pkg::LEGACY_LAST_WORD;
    s_d = s_q;
    hit = 1'b0;
    start = 1'b0;
    if (s_q.ctrl[eth_rx_pkg::ENHANCED_BIT]) begin
      last_word = eth_rx_pkg::ENHANCED_LAST_WORD;
    end
    s_d.rdata = 32'h0000_0000;

    // Register writes
    if (reg_write) begin
      if (reg_addr == eth_rx_pkg::CONTROL_OFFSET) begin
        s_d.ctrl = reg_wdata & eth_rx_pkg::CONTROL_MASK;
      end else if (reg_addr == eth_rx_pkg::STATION_LOW_OFFSET) begin
        s_d.st_low = reg_wdata;
      end else if (reg_addr == eth_rx_pkg::STATION_HIGH_OFFSET) begin
        s_d.st_high = reg_wdata[15:0];
      end
    end

    // Register reads, answered one cycle later, unmapped reads give zero
    if (reg_read) begin
      if (reg_addr == eth_rx_pkg::CONTROL_OFFSET) begin
        s_d.rdata = s_q.ctrl;
      end else if (reg_addr == eth_rx_pkg::STATION_LOW_OFFSET) begin
        s_d.rdata = s_q.st_low;
      end else if (reg_addr == eth_rx_pkg::STATION_HIGH_OFFSET) begin
        s_d.rdata = {16'h0000, s_q.st_high};
      end else if (reg_addr == eth_rx_pkg::WAKE_STATUS_OFFSET) begin
        s_d.rdata = {31'h0000_0000, s_q.wake};
      end
    end

    // Wake pattern matcher; a mismatch restarts the hunt at the very byte
    if (beat) begin
      if (s_q.match_on) begin
        if (rx_data == station_byte(s_q.pos, s_q.st_low, s_q.st_high)) begin
          if (s_q.pos == eth_rx_pkg::ADDR_LAST_BYTE) begin
            s_d.pos = 3'h0;
            if (s_q.rep == eth_rx_pkg::ADDR_LAST_REPEAT) begin
              hit = 1'b1;
              s_d.match_on = 1'b0;
            end else begin
              s_d.rep = s_q.rep + 4'h1;
            end
          end else begin
            s_d.pos = s_q.pos + 3'h1;
          end
        end else begin
          s_d.match_on = 1'b0;
          s_d.ff_run = (rx_data == eth_rx_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
        end
      end else if (rx_data == eth_rx_pkg::SYNC_BYTE) begin
        if (s_q.ff_run != eth_rx_pkg::SYNC_LEN) begin
          s_d.ff_run = s_q.ff_run + 3'h1; // Longer runs still qualify
        end
      end else if (s_q.ff_run == eth_rx_pkg::SYNC_LEN &&
                   rx_data == station_byte(3'h0, s_q.st_low, s_q.st_high)) begin
        start = 1'b1;
        s_d.match_on = 1'b1;
        s_d.pos = 3'h1;
        s_d.rep = 4'h0;
        s_d.ff_run = 3'h0;
      end else begin
        s_d.ff_run = 3'h0;
      end
    end

    // Sticky flag, a new hit beats a clear in the same cycle
    s_d.wake = (hit && s_q.ctrl[eth_rx_pkg::WAKE_ENABLE_BIT]) ||
               (s_q.wake && !clr_wake);

    // Frame parsing for the VLAN tag
    if (beat) begin
      s_d.count = s_q.count + 16'h0001;
      if (s_q.count == 16'h0000) begin
        s_d.vlan = 1'b0;
        s_d.prio = 3'h0;
      end
      if (s_q.count == eth_rx_pkg::TPID_HI_POS) begin
        s_d.tpid_hi = rx_data;
      end
      if (s_q.count == eth_rx_pkg::TPID_LO_POS) begin
        s_d.vlan = ({s_q.tpid_hi, rx_data} == eth_rx_pkg::VLAN_TPID);
      end
      if (s_q.count == eth_rx_pkg::TCI_POS && s_q.vlan) begin
        s_d.prio = rx_data[7:5]; // 7 is the top class
      end
      if (rx_last) begin
        s_d.len = s_q.count + 16'h0001;
        s_d.ptr = desc_buf_ptr;
        s_d.count = 16'h0000;
        s_d.match_on = 1'b0; // Pattern must lie inside one frame
        s_d.ff_run = 3'h0;
        s_d.wr = eth_rx_pkg::WR_EMIT;
        s_d.idx = 3'h0;
      end
    end

    // Descriptor writer, the stream stalls until the last word is queued
    case (s_q.wr)
      eth_rx_pkg::WR_IDLE: begin
      end
      eth_rx_pkg::WR_EMIT: begin
        if (buf_ready) begin
          if (s_q.idx == last_word) begin
            s_d.wr = eth_rx_pkg::WR_IDLE; // Legacy ends at word 1, so priority goes out in enhanced mode only
          end else begin
            s_d.idx = s_q.idx + 3'h1;
          end
        end
      end
      default: begin
        s_d.wr = eth_rx_pkg::WR_IDLE;
      end
    endcase
    s_d.rx_ready = (s_d.wr == eth_rx_pkg::WR_IDLE);
  end

  // Register the state, byte swap starts cleared
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= eth_rx_pkg::CONTROL_RESET;
      s_q.rx_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Descriptor buffer toward memory
  // ****************************************
  desc_buffer #(
    .WIDTH(eth_rx_pkg::BUFFER_WIDTH)
  ) u_buffer (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(buf_push),
    .in_data({s_q.idx, word}),
    .in_ready(buf_ready),
    .out_valid(desc_valid),
    .out_data(buf_out),
    .out_ready(desc_ready)
  );

  // Outputs
  assign desc_word = buf_out[31:0];
  assign desc_index = buf_out[34:32];
  assign reg_rdata = s_q.rdata;
  assign rx_ready = s_q.rx_ready;
  assign wake_event = s_q.wake;

  // ****************************************
  // Assertions
  // ****************************************
  wake_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
    hit && s_q.ctrl[eth_rx_pkg::WAKE_ENABLE_BIT] |=> wake_event)
    else $error("wake flag not set after pattern");

  start_after_sync_a: assert property (@(posedge clk_sys) disable iff (rst)
    start |-> s_q.ff_run == eth_rx_pkg::SYNC_LEN ##1 s_q.match_on && s_q.pos == 3'h1)
    else $error("match started without full sync run");

  sixteen_copies_a: assert property (@(posedge clk_sys) disable iff (rst)
    hit |-> s_q.rep == 4'hf && s_q.pos == 3'h5 && s_q.match_on)
    else $error("wake hit before sixteen copies");

  enable_gates_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(wake_event) |-> $past(s_q.ctrl[eth_rx_pkg::WAKE_ENABLE_BIT]) && $past(hit))
    else $error("wake flag rose while detection off");

  prio_capture_a: assert property (@(posedge clk_sys) disable iff (rst)
    beat && s_q.count == 16'h000e && s_q.vlan |=> s_q.prio == $past(rx_data[7:5]))
    else $error("priority not taken from tag");

  prio_field_a: assert property (@(posedge clk_sys) disable iff (rst)
    buf_push && s_q.idx == 3'h2 && !s_q.ctrl[eth_rx_pkg::BYTE_SWAP_BIT]
    |=> desc_valid ##0 1'b1 [*1] ##0 (desc_index != 3'h2 || desc_word[15:13] == s_q.prio))
    else $error("priority field misplaced");

  status_word_a: assert property (@(posedge clk_sys) disable iff (rst)
    buf_push && s_q.idx == 3'h0 && !s_q.ctrl[eth_rx_pkg::BYTE_SWAP_BIT]
    |-> word[27] && !word[31] && word[15:0] == s_q.len)
    else $error("status word layout wrong");

  swap_word_a: assert property (@(posedge clk_sys) disable iff (rst)
    buf_push && s_q.idx == 3'h0 && s_q.ctrl[eth_rx_pkg::BYTE_SWAP_BIT]
    |-> word[7:0] == 8'h08 && word[15:8] == 8'h00 && word[31:24] == s_q.len[7:0])
    else $error("swapped word layout wrong");

  swap_reset_a: assert property (@(posedge clk_sys)
    $past(rst) |-> !s_q.ctrl[eth_rx_pkg::BYTE_SWAP_BIT])
    else $error("byte swap not cleared by reset");

  wake_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    wake_event && !clr_wake |=> wake_event)
    else $error("wake flag dropped without clear");

  stall_frame_a: assert property (@(posedge clk_sys) disable iff (rst)
    beat && rx_last |=> !rx_ready [*2])
    else $error("stream not stalled for descriptor");

  wake_seen_c: cover property (@(posedge clk_sys) disable iff (rst) $rose(wake_event));
  vlan_desc_c: cover property (@(posedge clk_sys) disable iff (rst)
    buf_push && s_q.idx == 3'h2 && s_q.vlan);
  buffer_full_c: cover property (@(posedge clk_sys) disable iff (rst)
    s_q.wr == eth_rx_pkg::WR_EMIT && !buf_ready);

endmodule : eth_rx_desc_wake_pattern

// ==== eth_rx_pkg.sv ====
// Shared constants and types for the receive descriptor and wake pattern block
package eth_rx_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [31:0] CONTROL_OFFSET = 32'h400c0024;
  localparam logic [31:0] STATION_LOW_OFFSET = 32'h400c00e4;
  localparam logic [31:0] STATION_HIGH_OFFSET = 32'h400c00e8;
  localparam logic [31:0] WAKE_STATUS_OFFSET = 32'h400c0004;

  // ****************************************
  // Control fields and reset values
  // ****************************************
  localparam int WAKE_ENABLE_BIT = 2;
  localparam int ENHANCED_BIT = 4;
  localparam int BYTE_SWAP_BIT = 8;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_0114;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam int WAKE_FLAG_BIT = 0;

  // ****************************************
  // Wake pattern shape
  // ****************************************
  localparam logic [7:0] SYNC_BYTE = 8'hff;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [2:0] ADDR_LAST_BYTE = 3'h5;
  localparam logic [3:0] ADDR_LAST_REPEAT = 4'hf;

  // ****************************************
  // Frame parsing and descriptor layout
  // ****************************************
  localparam logic [15:0] VLAN_TPID = 16'h8100;
  localparam logic [15:0] TPID_HI_POS = 16'h000c;
  localparam logic [15:0] TPID_LO_POS = 16'h000d;
  localparam logic [15:0] TCI_POS = 16'h000e;
  localparam int EMPTY_BIT = 15;
  localparam int LAST_BIT = 11;
  localparam int PRIO_LSB = 13;
  localparam int VLAN_FLAG_BIT = 2;
  localparam logic [2:0] LEGACY_LAST_WORD = 3'h1;
  localparam logic [2:0] ENHANCED_LAST_WORD = 3'h7;
  localparam int BUFFER_WIDTH = 35;

  // Descriptor writer states
  typedef enum logic [0:0] {
    WR_IDLE,
    WR_EMIT
  } wr_state_type;

endpackage : eth_rx_pkg

// ==== rx_frame_source.sv ====
// Byte source standing in for the network side of the receive path
`timescale 1ns/10ps
module rx_frame_source (
  // Clock
  input wire logic clk_sys,
  // Byte stream toward the block
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_last,
  input wire logic rx_ready
);
  // Idle line before the first frame
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
  end

  // One frame; idle gaps between bytes mimic a slow link
  task automatic send(input logic [7:0] b[$], input int gap);
    for (int k = 0; k < b.size(); k++) begin
      rx_data <= b[k];
      rx_valid <= 1'b1;
      rx_last <= (k == b.size() - 1);
      @(posedge clk_sys);
      // Byte stays put until the block takes it
      while (rx_ready !== 1'b1) @(posedge clk_sys);
      if (gap > 0 && k < b.size() - 1) begin
        rx_valid <= 1'b0;
        rx_data <= ~b[k];
        repeat (gap) @(posedge clk_sys);
      end
    end
    // Released line must not look like a stale byte
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~b[b.size() - 1];
  endtask : send
endmodule : rx_frame_source

// ==== tb_eth_rx_desc_wake_pattern.sv ====
// Self-checking testbench for descriptor write-back and wake detection
`timescale 1ns/10ps
module tb_eth_rx_desc_wake_pattern;
  localparam logic [47:0] STATION = 48'h02a1b2c3d4e5;
  logic clk_sys;
  logic rst;
  logic [31:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [31:0] reg_rdata;
  logic [7:0] rx_data;
  logic rx_valid;
  logic rx_last;
  logic rx_ready;
  logic [31:0] desc_buf_ptr;
  logic [31:0] desc_word;
  logic [2:0] desc_index;
  logic desc_valid;
  logic desc_ready;
  logic wake_event;
  int n_mismatch;
  int samples_checked;
  int cycles;
  logic [31:0] got_word[$];
  logic [2:0] got_idx[$];
  logic [7:0] frame[$];

  eth_rx_desc_wake_pattern eth_rx_desc_wake_pattern_i (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
    .rx_ready(rx_ready), .desc_buf_ptr(desc_buf_ptr), .desc_word(desc_word),
    .desc_index(desc_index), .desc_valid(desc_valid), .desc_ready(desc_ready),
    .wake_event(wake_event));
  rx_frame_source rx_frame_source_i (.clk_sys(clk_sys), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready));

  // ****************************************
  // Clock, descriptor sink and hang guard
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Memory side: collect every accepted word
  always @(posedge clk_sys) begin
    if (desc_valid === 1'b1 && desc_ready === 1'b1) begin
      got_word.push_back(desc_word);
      got_idx.push_back(desc_index);
    end
  end

  // Whole run needs about a thousand cycles; this ceiling only catches hangs
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // One-cycle write strobe; a free edge follows before the next access
  task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : reg_wr

  // Read data stand only in the cycle after the read edge
  task automatic reg_rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    // Mid-cycle, where the answer has settled
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : reg_rd

  // Send the frame; the memory side may stall for the first cycles
  task automatic run_frame(input int n, input int stall, input int gap);
    got_word.delete();
    got_idx.delete();
    fork
      rx_frame_source_i.send(frame, gap);
      // Ready is only lowered when a stall is asked for, never toggled in one step
      if (stall > 0) begin
        desc_ready <= 1'b0;
        repeat (stall) @(posedge clk_sys);
        check("stream held", 32'(rx_ready), 32'h0);
        check("buffer words waiting", 32'(got_word.size()), 32'h0);
        desc_ready <= 1'b1;
      end
    join
    for (int w = 0; w < 300 && got_word.size() < n; w++) @(posedge clk_sys);
    repeat (3) @(posedge clk_sys);
  endtask : run_frame

  // Frame with the sync run and some address copies after a lead of three or more bytes
  task automatic build_wake(input int copies, input int lead);
    frame.delete();
    repeat (lead - 3) frame.push_back(8'h11);
    repeat (3) frame.push_back(8'h22);
    repeat (6) frame.push_back(8'hff);
    repeat (copies) for (int i = 5; i >= 0; i--) frame.push_back(STATION[8*i +: 8]);
    repeat (4) frame.push_back(8'h33);
  endtask : build_wake

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    reg_rd(eth_rx_pkg::CONTROL_OFFSET, d);
    check("control after reset", d, 32'h0);
    check("wake after reset", 32'(wake_event), 32'h0);
    reg_wr(eth_rx_pkg::CONTROL_OFFSET, 32'hffff_ffff);
    reg_wr(32'h400c_0100, 32'h0);
    reg_rd(eth_rx_pkg::CONTROL_OFFSET, d);
    check("control fields", d, eth_rx_pkg::CONTROL_MASK);
    reg_rd(32'h400c_0100, d);
    check("unmapped read", d, 32'h0);
    reg_wr(eth_rx_pkg::CONTROL_OFFSET, 32'h0);
    $display("registers done");
  endtask : t_regs

  // Table: enable, copies, lead length, expected wake
  task automatic t_wake();
    logic [31:0] d;
    int en[4] = '{1, 1, 0, 1};
    int cp[4] = '{16, 6, 16, 16};
    int ld[4] = '{17, 17, 17, 40};
    int ex[4] = '{1, 0, 0, 1};
    reg_wr(eth_rx_pkg::STATION_LOW_OFFSET, STATION[47:16]);
    reg_wr(eth_rx_pkg::STATION_HIGH_OFFSET, {16'h0000, STATION[15:0]});
    for (int c = 0; c < 4; c++) begin
      reg_wr(eth_rx_pkg::CONTROL_OFFSET, 32'(en[c]) << eth_rx_pkg::WAKE_ENABLE_BIT);
      desc_buf_ptr <= 32'h1000_0040 + 32'(c);
      build_wake(cp[c], ld[c]);
      run_frame(2, 0, 1 - c / 2);
      check("wake frame words", 32'(got_word.size()), 32'h2);
      check("wake frame ptr", got_word[1], 32'h1000_0040 + 32'(c));
      check("wake level", 32'(wake_event), 32'(ex[c]));
      reg_rd(eth_rx_pkg::WAKE_STATUS_OFFSET, d);
      check("wake flag", d, 32'(ex[c]));
      reg_wr(eth_rx_pkg::WAKE_STATUS_OFFSET, 32'h1);
      reg_rd(eth_rx_pkg::WAKE_STATUS_OFFSET, d);
      check("wake cleared", d | 32'(wake_event), 32'h0);
    end
    $display("wake pattern done");
  endtask : t_wake

  // Table: control, priority, word count, swap, stall
  task automatic t_desc();
    logic [31:0] e;
    logic [31:0] ctl[3] = '{32'h10, 32'h110, 32'h0};
    logic [2:0] pr[3] = '{3'h7, 3'h2, 3'h5};
    int n[3] = '{8, 8, 2};
    for (int c = 0; c < 3; c++) begin
      reg_wr(eth_rx_pkg::CONTROL_OFFSET, ctl[c]);
      desc_buf_ptr <= 32'h2000_1230 + 32'(c);
      frame.delete();
      repeat (12) frame.push_back(8'h44);
      frame.push_back(8'h81);
      frame.push_back(8'h00);
      frame.push_back({pr[c], 5'h00});
      repeat (41) frame.push_back(8'h55);
      run_frame(n[c], (c == 0) ? 90 : 0, 0);
      check("word count", 32'(got_word.size()), 32'(n[c]));
      for (int w = 0; w < n[c] && w < got_word.size(); w++) begin
        case (w)
          // Empty clear, last set, then the frame length
          0: e = {16'h0800, 16'(frame.size())};
          1: e = desc_buf_ptr;
          // Priority on top of the halfword at 0xa, VLAN flag in bit 2
          2: e = {16'h0000, pr[c], 13'h0004};
          default: e = 32'h0;
        endcase
        if (ctl[c][8]) e = {<<8{e}};
        check("desc index", 32'(got_idx[w]), 32'(w));
        check("desc word", got_word[w], e);
      end
    end
    $display("descriptor done");
  endtask : t_desc

  // Reset in mid-run must clear fields that software had set
  task automatic t_reset();
    logic [31:0] d;
    reg_wr(eth_rx_pkg::CONTROL_OFFSET, 32'h0000_0114);
    reg_rd(eth_rx_pkg::CONTROL_OFFSET, d);
    check("control before reset", d, eth_rx_pkg::CONTROL_MASK);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    reg_rd(eth_rx_pkg::CONTROL_OFFSET, d);
    check("control after second reset", d, 32'h0);
    $display("second reset done");
  endtask : t_reset

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    reg_addr = 32'h0;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    desc_buf_ptr = 32'h0;
    desc_ready = 1'b1;
    n_mismatch = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_wake();
    t_desc();
    t_reset();
    tally_and_finish();
  end
endmodule : tb_eth_rx_desc_wake_pattern
